// ==== common/sac_consts.svh ====
// Register offsets, field positions, reset values and timing counts of the ADC/comparator block
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH
// ==========================================
// Register byte offsets
`define SAC_OFS_CTRL 6'h00
`define SAC_OFS_STAT 6'h04
`define SAC_OFS_RES 6'h08
`define SAC_OFS_ACC 6'h0c
`define SAC_OFS_BCFG 6'h10
`define SAC_OFS_BBASE 6'h14
`define SAC_OFS_BLEN 6'h18
`define SAC_OFS_BPTR 6'h1c
`define SAC_OFS_CMP 6'h20
// ==========================================
// Control fields
`define SAC_C_START 0
`define SAC_C_CONT 1
`define SAC_C_DIV 3:2
`define SAC_C_SAMP 5:4
`define SAC_C_CHAN 8:6
`define SAC_C_GAIN 9
`define SAC_C_EXTREF 10
`define SAC_C_ACCEN 11
`define SAC_C_ACCN 13:12
`define SAC_C_ACCIRQ 14
`define SAC_C_BUF 15
`define SAC_CTRL_RST 16'h0000
// Buffer configuration fields
`define SAC_B_TSEL 2:0
`define SAC_B_WRAP 3
`define SAC_B_MASK 9:4
`define SAC_B_IHALF 10
`define SAC_B_IFULL 11
`define SAC_B_IOVF 12
`define SAC_BCFG_RST 13'h0000
// Status bits
`define SAC_S_DONE 0
`define SAC_S_BUSY 1
`define SAC_S_HALF 2
`define SAC_S_FULL 3
`define SAC_S_OVF 4
`define SAC_S_CMP 5
`define SAC_S_CEVT 6
`define SAC_S_WAKE 7
// Comparator fields
`define SAC_K_EN 0
`define SAC_K_LP 1
`define SAC_K_HYS 3:2
`define SAC_K_NEG 5:4
`define SAC_K_POS 6
`define SAC_K_WEN 7
`define SAC_K_WRISE 8
`define SAC_K_IEN 9
`define SAC_CMP_RST 10'h000
// ==========================================
// Timing
`define SAC_CLK_MHZ 125
`define SAC_SRC_MHZ 16
`define SAC_DIV_BASE 8
`define SAC_CONV_FIXED 13
`define SAC_SAR_MSB 10'h200
`define SAC_CHAN_SUPPLY 3'h5
`define SAC_NEG_REF 2'h0
`endif

// ==== common/sac_pkg.sv ====
// Types shared by the ADC/comparator control block
package sac_pkg;
	typedef enum logic [1:0] {sac_idle, sac_samp, sac_conv} sac_state_e;
	typedef logic [9:0] sac_code_t;
endpackage

// ==== rtl/sac_top.sv ====
// SAR ADC sequencing, sample buffer DMA and comparator control with an Avalon-MM slave
// Behaviour
// - Converter clock divided from 16MHz to 2MHz, 1MHz, 500kHz or 250kHz.
// - Each conversion samples for 2, 4, 6 or 8 converter clocks, then holds.
// - A conversion takes three sample periods plus thirteen converter clocks.
// - Single mode and continuous mode restarting right after each conversion.
// - Ten-bit result by successive approximation.
// - Channel selector picks one of six inputs, four external, temperature, supply.
// - Gain bit 0 spans the reference, 1 spans twice the reference.
// - Reference chosen between internal bandgap and external pin.
// - Completion raises an interrupt and a pollable status.
// - Accumulator sums 2, 4, 8 or 16 results; software rounds.
// - With accumulation, completion may be reported only at period end.
// - Supply divider enabled only while a supply measurement runs.
// - Buffer mode triggers from a selected timer 0 to 4.
// - Buffer results go by DMA as 16-bit words, up to 2047.
// - With wrap on, pointer returns to start after last location.
// - Half-full, full and overflow buffer interrupts each enabled separately.
// - Each trigger converts every selected input into consecutive locations.
// - Comparator hysteresis selects one of four settings.
// - Comparator negative and positive input sources are selectable.
// - Comparator output readable, may interrupt, and can be disabled.
// - Only low-power comparator wakes from sleep, negative input from a pin.
// - Software enables wakeup and picks rising or falling active edge.
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.svh"
module sac_top (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Avalon-MM slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Timer triggers and DMA
	input wire logic [4:0] timer_trig,
	output logic dma_req,
	output logic [31:0] dma_addr,
	output logic [15:0] dma_data,
	input wire logic dma_ack,
	// Converter analogue side
	input wire logic sar_cmp,
	output sac_pkg::sac_code_t sar_code,
	output logic sar_sample,
	output logic [2:0] adc_chan,
	output logic adc_gain,
	output logic adc_ext_ref,
	output logic supply_mon_en,
	// Comparator analogue side
	input wire logic cmp_raw,
	output logic cmp_enable,
	output logic cmp_low_power,
	output logic [1:0] cmp_hyst,
	output logic [1:0] cmp_neg_sel,
	output logic cmp_pos_sel,
	// Event outputs
	output logic adc_irq,
	output logic buf_irq,
	output logic cmp_irq,
	output logic cmp_wake
);
	import sac_pkg::*;

	// ==========================================
	// Bus slave
	logic wr_ok;
	logic rd_first;
	logic [15:0] ctrl;
	logic [12:0] bcfg;
	logic [31:0] bbase;
	logic [10:0] blen;
	logic [9:0] kcfg;
	logic [7:0] stat;
	logic [9:0] result;
	logic [13:0] acc_q;
	logic [10:0] ptr;
	logic [31:0] next_rdata;

	assign wr_ok = avs_write && !avs_waitrequest;
	assign rd_first = avs_read && avs_waitrequest;

	// One wait state on every access keeps read data a flop away from the decoder
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (avs_address)
			`SAC_OFS_CTRL: next_rdata = {16'h0000, ctrl};
			`SAC_OFS_STAT: next_rdata = {24'h00_0000, stat};
			`SAC_OFS_RES: next_rdata = {22'h00_0000, result};
			`SAC_OFS_ACC: next_rdata = {18'h0_0000, acc_q};
			`SAC_OFS_BCFG: next_rdata = {19'h0_0000, bcfg};
			`SAC_OFS_BBASE: next_rdata = bbase;
			`SAC_OFS_BLEN: next_rdata = {21'h00_0000, blen};
			`SAC_OFS_BPTR: next_rdata = {21'h00_0000, ptr};
			`SAC_OFS_CMP: next_rdata = {22'h00_0000, kcfg};
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			avs_readdata <= 32'h0000_0000;
		end else if (rd_first) begin
			avs_readdata <= next_rdata;
		end
	end

	// Start bit is a command and never stored
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl <= `SAC_CTRL_RST;
			bcfg <= `SAC_BCFG_RST;
			bbase <= 32'h0000_0000;
			blen <= 11'h000;
			kcfg <= `SAC_CMP_RST;
		end else if (wr_ok) begin
			case (avs_address)
				`SAC_OFS_CTRL: ctrl <= {avs_writedata[15:1], 1'b0};
				`SAC_OFS_BCFG: bcfg <= avs_writedata[12:0];
				`SAC_OFS_BBASE: bbase <= {avs_writedata[31:1], 1'b0};
				`SAC_OFS_BLEN: blen <= avs_writedata[10:0];
				`SAC_OFS_CMP: kcfg <= avs_writedata[9:0];
				default: ;
			endcase
		end
	end

	// ==========================================
	// Converter clock enable
	logic [7:0] frac;
	logic [7:0] frac_sum;
	logic src_tick;
	logic [5:0] div_cnt;
	logic [5:0] div_last;
	logic adc_tick;

	// 16 MHz does not divide 125 MHz, so an accumulator spreads the pulses
	assign frac_sum = frac + 8'(`SAC_SRC_MHZ);
	assign div_last = 6'((`SAC_DIV_BASE << ctrl[`SAC_C_DIV]) - 1);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			frac <= 8'h00;
			src_tick <= 1'b0;
		end else if (frac_sum >= 8'(`SAC_CLK_MHZ)) begin
			frac <= frac_sum - 8'(`SAC_CLK_MHZ);
			src_tick <= 1'b1;
		end else begin
			frac <= frac_sum;
			src_tick <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_cnt <= 6'h00;
			adc_tick <= 1'b0;
		end else begin
			adc_tick <= 1'b0;
			if (src_tick) begin
				if (div_cnt >= div_last) begin
					div_cnt <= 6'h00;
					adc_tick <= 1'b1;
				end else begin
					div_cnt <= div_cnt + 6'h01;
				end
			end
		end
	end

	// ==========================================
	// Input synchronisers
	logic sar_s1, sar_s2, sar_s3, sar_lvl;
	logic cmp_s1, cmp_s2, cmp_s3, cmp_lvl;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			{sar_s1, sar_s2, sar_s3, sar_lvl} <= 4'h0;
			{cmp_s1, cmp_s2, cmp_s3, cmp_lvl} <= 4'h0;
		end else begin
			{sar_s1, sar_s2, sar_s3} <= {sar_cmp, sar_s1, sar_s2};
			{cmp_s1, cmp_s2, cmp_s3} <= {cmp_raw, cmp_s1, cmp_s2};
			if (sar_s2 == sar_s3) sar_lvl <= sar_s3;
			if (cmp_s2 == cmp_s3) cmp_lvl <= cmp_s3;
		end
	end

	// ==========================================
	// Conversion sequencer
	sac_state_e st;
	logic [5:0] cnt;
	logic [3:0] samp_q;
	logic [5:0] conv_len;
	logic [2:0] chan_q;
	logic start_pend;
	logic [5:0] scan_mask;
	logic [2:0] scan_low;
	logic go_buf;
	logic accept;
	logic cont_on;
	logic conv_done;
	logic [5:0] tick_cnt;
	logic [5:0] last_len;
	logic [3:0] samp_len;

	// Widened before the add, since 6 plus 2 does not fit three bits
	assign samp_len = {1'b0, ctrl[`SAC_C_SAMP], 1'b0} + 4'h2;
	assign conv_len = 6'((samp_q << 1) + `SAC_CONV_FIXED);
	assign cont_on = ctrl[`SAC_C_CONT] && !ctrl[`SAC_C_BUF];
	assign go_buf = ctrl[`SAC_C_BUF] && |scan_mask && !dma_req && !conv_done;
	assign accept = (st == sac_idle) && adc_tick && (start_pend || go_buf);

	always_comb begin
		scan_low = 3'h0;
		for (int i = 5; i >= 0; i--) begin
			if (scan_mask[i]) scan_low = 3'(i);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			start_pend <= 1'b0;
		end else if (wr_ok && avs_address == `SAC_OFS_CTRL && avs_writedata[`SAC_C_START]) begin
			start_pend <= 1'b1;
		end else if (accept) begin
			start_pend <= 1'b0;
		end
	end

	// A trigger arriving while scan channels are still waiting to start is dropped
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			scan_mask <= 6'h00;
		end else if (!ctrl[`SAC_C_BUF]) begin
			scan_mask <= 6'h00;
		end else if (scan_mask == 6'h00 && bcfg[`SAC_B_TSEL] <= 3'h4
			&& timer_trig[bcfg[`SAC_B_TSEL]]) begin
			scan_mask <= bcfg[`SAC_B_MASK];
		end else if (accept && !start_pend) begin
			scan_mask[scan_low] <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= sac_idle;
			cnt <= 6'h00;
			samp_q <= 4'h2;
			chan_q <= 3'h0;
			sar_code <= 10'h000;
			sar_sample <= 1'b0;
			supply_mon_en <= 1'b0;
			conv_done <= 1'b0;
			result <= 10'h000;
		end else begin
			conv_done <= 1'b0;
			if (adc_tick) begin
				case (st)
					sac_idle: if (accept) begin
						st <= sac_samp;
						samp_q <= samp_len;
						cnt <= {2'b00, samp_len};
						chan_q <= start_pend ? ctrl[`SAC_C_CHAN] : scan_low;
						supply_mon_en <= (start_pend ? ctrl[`SAC_C_CHAN] : scan_low)
							== `SAC_CHAN_SUPPLY;
						sar_sample <= 1'b1;
					end
					sac_samp: if (cnt == 6'h01) begin
						st <= sac_conv;
						cnt <= conv_len;
						sar_sample <= 1'b0;
						sar_code <= `SAC_SAR_MSB;
					end else begin
						cnt <= cnt - 6'h01;
					end
					sac_conv: begin
						if (cnt <= 6'd10) begin
							if (!sar_lvl) sar_code[4'(cnt - 6'h01)] <= 1'b0;
							if (cnt > 6'h01) sar_code[4'(cnt - 6'h02)] <= 1'b1;
						end
						if (cnt == 6'h01) begin
							conv_done <= 1'b1;
							result <= {sar_code[9:1], sar_code[0] & sar_lvl};
							if (cont_on) begin
								st <= sac_samp;
								samp_q <= samp_len;
								cnt <= {2'b00, samp_len};
								chan_q <= ctrl[`SAC_C_CHAN];
								supply_mon_en <= ctrl[`SAC_C_CHAN] == `SAC_CHAN_SUPPLY;
								sar_sample <= 1'b1;
							end else begin
								st <= sac_idle;
								supply_mon_en <= 1'b0;
							end
						end else begin
							cnt <= cnt - 6'h01;
						end
					end
					default: st <= sac_idle;
				endcase
			end
		end
	end

	// Gain and reference drive the analogue front end straight from control
	assign adc_chan = chan_q;
	assign adc_gain = ctrl[`SAC_C_GAIN];
	assign adc_ext_ref = ctrl[`SAC_C_EXTREF];

	// Helper for the length check only
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_cnt <= 6'h00;
			last_len <= 6'h00;
		end else if (adc_tick) begin
			if (st == sac_idle || (st == sac_conv && cnt == 6'h01)) tick_cnt <= 6'h00;
			else tick_cnt <= tick_cnt + 6'h01;
			if (st == sac_conv && cnt == 6'h01) last_len <= tick_cnt + 6'h01;
		end
	end

	// ==========================================
	// Accumulator
	logic [3:0] acc_n;
	logic [13:0] acc_sum;
	logic [13:0] acc_next;
	logic [4:0] acc_target;
	logic acc_end;

	assign acc_target = 5'(5'h02 << ctrl[`SAC_C_ACCN]);
	assign acc_next = (acc_n == 4'h0) ? 14'(result) : acc_sum + 14'(result);
	assign acc_end = conv_done && ctrl[`SAC_C_ACCEN] && 5'(acc_n) == acc_target - 5'h01;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			acc_n <= 4'h0;
			acc_sum <= 14'h0000;
			acc_q <= 14'h0000;
		end else if (!ctrl[`SAC_C_ACCEN]) begin
			acc_n <= 4'h0;
		end else if (conv_done) begin
			acc_sum <= acc_next;
			if (acc_end) begin
				acc_q <= acc_next;
				acc_n <= 4'h0;
			end else begin
				acc_n <= acc_n + 4'h1;
			end
		end
	end

	// ==========================================
	// Sample buffer DMA
	logic buf_full;
	logic buf_take;
	logic buf_ovf;
	logic [10:0] ptr_inc;

	assign buf_full = ptr >= blen;
	assign buf_take = conv_done && ctrl[`SAC_C_BUF] && !(buf_full && !bcfg[`SAC_B_WRAP]);
	assign buf_ovf = conv_done && ctrl[`SAC_C_BUF] && buf_full && !bcfg[`SAC_B_WRAP];
	assign ptr_inc = (buf_full ? 11'h000 : ptr) + 11'h001;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ptr <= 11'h000;
			dma_req <= 1'b0;
			dma_addr <= 32'h0000_0000;
			dma_data <= 16'h0000;
		end else begin
			if (dma_ack) dma_req <= 1'b0;
			if (wr_ok && avs_address == `SAC_OFS_BPTR) begin
				ptr <= 11'h000;
			end else if (buf_take) begin
				dma_req <= 1'b1;
				dma_addr <= bbase + {20'h0_0000, buf_full ? 11'h000 : ptr, 1'b0};
				dma_data <= {6'h00, result};
				if (ptr_inc >= blen && bcfg[`SAC_B_WRAP]) ptr <= 11'h000;
				else ptr <= ptr_inc;
			end
		end
	end

	// ==========================================
	// Status flags, set wins over write-one-to-clear
	logic done_evt;
	logic half_evt;
	logic full_evt;
	logic cmp_evt;
	logic wake_evt;
	logic [7:0] clr;

	assign done_evt = conv_done && (!ctrl[`SAC_C_ACCEN] || !ctrl[`SAC_C_ACCIRQ] || acc_end);
	assign half_evt = buf_take && ptr_inc == (blen >> 1);
	assign full_evt = buf_take && ptr_inc >= blen;
	assign cmp_evt = kcfg[`SAC_K_EN] && (cmp_s2 == cmp_s3) && (cmp_s3 != cmp_lvl);
	assign wake_evt = cmp_evt && kcfg[`SAC_K_WEN] && kcfg[`SAC_K_LP]
		&& kcfg[`SAC_K_NEG] != `SAC_NEG_REF && cmp_s3 == kcfg[`SAC_K_WRISE];
	assign clr = (wr_ok && avs_address == `SAC_OFS_STAT) ? avs_writedata[7:0] : 8'h00;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			stat <= 8'h00;
		end else begin
			stat[`SAC_S_DONE] <= done_evt || (stat[`SAC_S_DONE] && !clr[`SAC_S_DONE]);
			stat[`SAC_S_BUSY] <= st != sac_idle;
			stat[`SAC_S_HALF] <= half_evt || (stat[`SAC_S_HALF] && !clr[`SAC_S_HALF]);
			stat[`SAC_S_FULL] <= full_evt || (stat[`SAC_S_FULL] && !clr[`SAC_S_FULL]);
			stat[`SAC_S_OVF] <= buf_ovf || (stat[`SAC_S_OVF] && !clr[`SAC_S_OVF]);
			stat[`SAC_S_CMP] <= cmp_lvl;
			stat[`SAC_S_CEVT] <= cmp_evt || (stat[`SAC_S_CEVT] && !clr[`SAC_S_CEVT]);
			stat[`SAC_S_WAKE] <= wake_evt || (stat[`SAC_S_WAKE] && !clr[`SAC_S_WAKE]);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			adc_irq <= 1'b0;
			buf_irq <= 1'b0;
			cmp_irq <= 1'b0;
			cmp_wake <= 1'b0;
		end else begin
			adc_irq <= stat[`SAC_S_DONE];
			buf_irq <= |(stat[`SAC_S_OVF:`SAC_S_HALF] & bcfg[`SAC_B_IOVF:`SAC_B_IHALF]);
			cmp_irq <= stat[`SAC_S_CEVT] && kcfg[`SAC_K_IEN];
			cmp_wake <= stat[`SAC_S_WAKE];
		end
	end

	// Comparator controls come straight from their register
	assign cmp_enable = kcfg[`SAC_K_EN];
	assign cmp_low_power = kcfg[`SAC_K_LP];
	assign cmp_hyst = kcfg[`SAC_K_HYS];
	assign cmp_neg_sel = kcfg[`SAC_K_NEG];
	assign cmp_pos_sel = kcfg[`SAC_K_POS];

	// ==========================================
	// Assertions
	property p_div_gap;
		@(posedge core_clk) disable iff (!rst_b)
		adc_tick |=> !adc_tick [*8];
	endproperty
	a_div_gap: assert property (p_div_gap) else $error("converter clock too fast");

	property p_conv_len;
		@(posedge core_clk) disable iff (!rst_b)
		conv_done |=> last_len == 6'(3 * samp_q + `SAC_CONV_FIXED);
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

	property p_cont;
		@(posedge core_clk) disable iff (!rst_b)
		conv_done && $past(cont_on) |-> st == sac_samp && sar_sample;
	endproperty
	a_cont: assert property (p_cont) else $error("continuous restart missed");

	property p_supply;
		@(posedge core_clk) disable iff (!rst_b)
		supply_mon_en |-> st != sac_idle && chan_q == `SAC_CHAN_SUPPLY;
	endproperty
	a_supply: assert property (p_supply) else $error("supply divider on when idle");

	property p_done;
		@(posedge core_clk) disable iff (!rst_b)
		conv_done && !ctrl[`SAC_C_ACCEN] |=> stat[`SAC_S_DONE] ##1 adc_irq;
	endproperty
	a_done: assert property (p_done) else $error("completion not reported");

	property p_acc;
		@(posedge core_clk) disable iff (!rst_b)
		acc_end |=> acc_n == 4'h0 && acc_q == $past(acc_next);
	endproperty
	a_acc: assert property (p_acc) else $error("accumulation period wrong");

	property p_wrap;
		@(posedge core_clk) disable iff (!rst_b)
		buf_take && bcfg[`SAC_B_WRAP] && ptr_inc == blen |=> ptr == 11'h000 && dma_req;
	endproperty
	a_wrap: assert property (p_wrap) else $error("buffer did not wrap");

	property p_ovf;
		@(posedge core_clk) disable iff (!rst_b)
		buf_ovf |=> stat[`SAC_S_OVF] && $stable(ptr) && $stable(dma_addr);
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow not handled");
endmodule // sac_top
`default_nettype wire

// ==== tb/sac_analog_model.sv ====
// Far side of the block: channel levels, SAR comparator and DMA acknowledge
`timescale 1ns/1ps
`default_nettype none
module sac_analog_model #(
	parameter int ACK_WAIT = 3
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Converter side
	input wire sac_pkg::sac_code_t sar_code,
	input wire logic [2:0] adc_chan,
	output logic sar_cmp,
	// DMA side
	input wire logic dma_req,
	output logic dma_ack
);
	import sac_pkg::*;
	int wait_cnt;
	// ==========================================
	// Levels
	// Each channel holds its own level, so a wrong channel pick shows in the code
	always_comb sar_cmp = (10'(10'h0a5 + 10'(adc_chan) * 10'h06b) >= sar_code);
	// ==========================================
	// DMA acknowledge
	// Late ack on purpose: the block must hold the request meanwhile
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_cnt <= 0;
			dma_ack <= 1'b0;
		end else begin
			dma_ack <= dma_req && !dma_ack && wait_cnt == ACK_WAIT;
			wait_cnt <= (dma_req && !dma_ack && wait_cnt < ACK_WAIT) ? wait_cnt + 1 : 0;
		end
	end
endmodule // sac_analog_model
`default_nettype wire

// ==== tb/test_sac_top.sv ====
// Self-checking bench of the ADC and comparator control block
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.svh"
module test_sac_top;
	import sac_pkg::*;
	// ==========================================
	// Signals
	logic core_clk, rst_b, avs_read, avs_write, avs_waitrequest, sar_cmp, sar_sample;
	logic dma_req, dma_ack, cmp_raw, adc_gain, adc_ext_ref, supply_mon_en, cmp_enable;
	logic cmp_low_power, cmp_pos_sel, adc_irq, buf_irq, cmp_irq, cmp_wake;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, dma_addr, rdata;
	logic [4:0] timer_trig;
	logic [15:0] dma_data;
	logic [2:0] adc_chan;
	logic [1:0] cmp_hyst, cmp_neg_sel;
	sac_code_t sar_code;
	logic [31:0] addr_log [0:7];
	logic [15:0] data_log [0:7];
	int fails = 0;
	int n_checks = 0;
	int n_dma = 0;
	sac_top i_sac_top (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.timer_trig(timer_trig), .dma_req(dma_req), .dma_addr(dma_addr),
		.dma_data(dma_data), .dma_ack(dma_ack), .sar_cmp(sar_cmp), .sar_code(sar_code),
		.sar_sample(sar_sample), .adc_chan(adc_chan), .adc_gain(adc_gain),
		.adc_ext_ref(adc_ext_ref), .supply_mon_en(supply_mon_en), .cmp_raw(cmp_raw),
		.cmp_enable(cmp_enable), .cmp_low_power(cmp_low_power), .cmp_hyst(cmp_hyst),
		.cmp_neg_sel(cmp_neg_sel), .cmp_pos_sel(cmp_pos_sel), .adc_irq(adc_irq),
		.buf_irq(buf_irq), .cmp_irq(cmp_irq), .cmp_wake(cmp_wake));
	sac_analog_model #(.ACK_WAIT(3)) i_sac_analog_model (.core_clk(core_clk), .rst_b(rst_b),
		.sar_code(sar_code), .adc_chan(adc_chan), .sar_cmp(sar_cmp), .dma_req(dma_req),
		.dma_ack(dma_ack));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// ==========================================
	// DMA log, taken at the acknowledge edge
	always @(posedge core_clk) begin
		if (dma_req === 1'b1 && dma_ack === 1'b1) begin
			addr_log[n_dma % 8] <= dma_addr;
			data_log[n_dma % 8] <= dma_data;
			n_dma <= n_dma + 1;
		end
	end
	// ==========================================
	// Helpers
	function automatic logic [31:0] vin(input int c);
		return 32'(10'h0a5 + 10'(c) * 10'h06b);
	endfunction
	task automatic conclude();
		if (fails == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chk_rng(input string name, input int lo, input int hi, input int got);
		n_checks++;
		if (got < lo || got > hi) begin
			fails++;
			$display("BAD %s expected %0d..%0d seen %0d", name, lo, hi, got);
		end
	endtask
	// Request stands until the rising edge at which waitrequest is seen low
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 64);
		rdata = avs_readdata;
		if (n >= 64) fails++;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		#1;
	endtask
	task automatic wait_lv(ref logic s, input logic v, input int lim, output int n);
		for (n = 0; n < lim && s !== v; n++) begin
			@(posedge core_clk);
			#1;
		end
		if (n >= lim) fails++;
	endtask
	task automatic idle();
		int i;
		for (i = 0; i < 3000; i++) begin
			bus(0, `SAC_OFS_STAT, 32'h0);
			if (rdata[`SAC_S_BUSY] === 1'b0) break;
		end
		if (i >= 3000) fails++;
	endtask
	task automatic trig(input int b, input int k, input int lim);
		int n0, i;
		n0 = n_dma;
		@(posedge core_clk);
		timer_trig <= 5'(1 << b);
		@(posedge core_clk);
		timer_trig <= 5'h00;
		for (i = 0; i < lim && n_dma < n0 + k; i++) @(posedge core_clk);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset();
		chk("idle_outs", 32'h1, 32'({dma_req, adc_irq, buf_irq, cmp_irq, cmp_wake, avs_waitrequest}));
		bus(1, 6'h24, 32'hffff_ffff);
		bus(0, 6'h24, 32'h0);
		chk("unmapped", 32'h0, rdata);
		bus(0, `SAC_OFS_CTRL, 32'h0);
		chk("ctrl_rst", 32'h0, rdata);
		bus(0, `SAC_OFS_CMP, 32'h0);
		chk("cmp_rst", 32'h0, rdata);
	endtask
	task automatic t_conv(input int div, input int samp, input int ch);
		int n, exp, tol;
		exp = (3 * (2 * samp + 2) + 13) * (8 << div) * 125 / 16;
		tol = (8 << div) * 8;
		bus(1, `SAC_OFS_CTRL, 32'(1 | div << 2 | samp << 4 | ch << 6 | 3 << 9));
		wait_lv(sar_sample, 1'b1, 1000, n);
		repeat (4) @(posedge core_clk);
		#1;
		chk("supply_mon_en", 32'(ch == 5), 32'(supply_mon_en));
		chk("adc_chan", 32'(ch), 32'(adc_chan));
		chk("gain_ref", 32'h3, 32'({adc_ext_ref, adc_gain}));
		wait_lv(adc_irq, 1'b1, 20000, n);
		chk_rng("conv_cycles", exp - tol, exp + tol, n + 4);
		chk("supply_off", 32'h0, 32'(supply_mon_en));
		bus(0, `SAC_OFS_STAT, 32'h0);
		chk("done", 32'h1, 32'(rdata[`SAC_S_DONE]));
		bus(0, `SAC_OFS_RES, 32'h0);
		chk("result", vin(ch), rdata);
		bus(1, `SAC_OFS_STAT, 32'h1);
		repeat (3) @(posedge core_clk);
		#1;
		chk("irq_clear", 32'h0, 32'(adc_irq));
	endtask
	task automatic t_cont();
		int n;
		bus(1, `SAC_OFS_CTRL, 32'h3);
		wait_lv(sar_sample, 1'b1, 1000, n);
		wait_lv(sar_sample, 1'b0, 1000, n);
		wait_lv(sar_sample, 1'b1, 2000, n);
		chk_rng("restart_gap", 1000, 1126, n);
		bus(1, `SAC_OFS_CTRL, 32'h0);
		idle();
		bus(1, `SAC_OFS_STAT, 32'h1);
		// The interrupt line follows the cleared flag one cycle later
		repeat (2) @(posedge core_clk);
	endtask
	task automatic t_acc();
		int n, p, k;
		for (p = 0; p < 2; p++) begin
			for (k = 0; k < 4; k++) begin
				chk("acc_early", 32'h0, 32'(adc_irq));
				bus(1, `SAC_OFS_CTRL, 32'h5841);
				wait_lv(sar_sample, 1'b1, 1000, n);
				idle();
			end
			wait_lv(adc_irq, 1'b1, 8, n);
			bus(0, `SAC_OFS_ACC, 32'h0);
			chk("acc_sum", 4 * vin(1), rdata);
			bus(1, `SAC_OFS_STAT, 32'h1);
			repeat (3) @(posedge core_clk);
		end
	endtask
	task automatic t_buf();
		bus(1, `SAC_OFS_BBASE, 32'h100);
		bus(1, `SAC_OFS_BLEN, 32'h3);
		bus(1, `SAC_OFS_BPTR, 32'h0);
		bus(1, `SAC_OFS_BCFG, 32'h1d12);
		bus(1, `SAC_OFS_CTRL, 32'h8000);
		trig(0, 1, 3000);
		chk("no_trig", 32'h0, 32'(n_dma));
		trig(2, 2, 6000);
		chk("n_dma", 32'h2, 32'(n_dma));
		chk("addr1", 32'h102, addr_log[1]);
		chk("data1", vin(4), 32'(data_log[1]));
		bus(0, `SAC_OFS_STAT, 32'h0);
		chk("half", 32'h1, 32'(rdata[`SAC_S_HALF]));
		trig(2, 2, 6000);
		chk("ovf_drop", 32'h3, 32'(n_dma));
		chk("addr2", 32'h104, addr_log[2]);
		bus(0, `SAC_OFS_STAT, 32'h0);
		chk("full_ovf", 32'h3, 32'(rdata[4:3]));
		chk("buf_irq", 32'h1, 32'(buf_irq));
		bus(1, `SAC_OFS_STAT, 32'h1c);
		bus(1, `SAC_OFS_BPTR, 32'h0);
		bus(1, `SAC_OFS_BCFG, 32'h1d1a);
		trig(2, 2, 6000);
		trig(2, 2, 6000);
		chk("wrap_n", 32'h7, 32'(n_dma));
		chk("wrap_addr", 32'h100, addr_log[6]);
		chk("wrap_data", vin(4), 32'(data_log[6]));
		bus(0, `SAC_OFS_STAT, 32'h0);
		chk("wrap_ovf", 32'h0, 32'(rdata[`SAC_S_OVF]));
		bus(1, `SAC_OFS_CTRL, 32'h0);
	endtask
	task automatic t_cmp();
		int i, n;
		logic [31:0] cfg [0:3];
		cfg = '{32'h3df, 32'h3cf, 32'h3dd, 32'h3de};
		for (i = 0; i < 12; i++) begin
			bus(1, `SAC_OFS_CMP, 32'(1 | (i % 4) << 2 | (i / 4) << 4));
			chk("cmp_sel", 32'(i), 32'({cmp_neg_sel, cmp_hyst}));
		end
		bus(1, `SAC_OFS_CMP, cfg[0]);
		chk("cmp_pins", 32'h7, 32'({cmp_enable, cmp_low_power, cmp_pos_sel}));
		@(posedge core_clk) cmp_raw <= 1'b1;
		wait_lv(cmp_wake, 1'b1, 40, n);
		bus(0, `SAC_OFS_STAT, 32'h0);
		chk("cmp_wake", 32'h3, 32'({rdata[`SAC_S_WAKE], rdata[`SAC_S_CMP]}));
		chk("cmp_irq", 32'h1, 32'(cmp_irq));
		// Falling edge selected as the wakeup edge
		bus(1, `SAC_OFS_STAT, 32'hc0);
		bus(1, `SAC_OFS_CMP, 32'h2df);
		@(posedge core_clk) cmp_raw <= 1'b0;
		wait_lv(cmp_wake, 1'b1, 40, n);
		chk("wake_fall", 32'h1, 32'(cmp_wake));
		// Falling edge with rising selected, internal reference, normal power, disabled
		for (i = 0; i < 4; i++) begin
			@(posedge core_clk) cmp_raw <= (i == 0);
			bus(1, `SAC_OFS_CMP, cfg[i]);
			repeat (10) @(posedge core_clk);
			bus(1, `SAC_OFS_STAT, 32'hc0);
			@(posedge core_clk) cmp_raw <= (i != 0);
			repeat (10) @(posedge core_clk);
			bus(0, `SAC_OFS_STAT, 32'h0);
			chk("no_wake", 32'h0, 32'(rdata[`SAC_S_WAKE]));
		end
		chk("cmp_off", 32'h0, 32'(cmp_enable));
	endtask
	// ==========================================
	// Main sequence and watchdog
	initial begin
		rst_b = 1'b0;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		timer_trig = 5'h00;
		cmp_raw = 1'b0;
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		#1;
		t_reset();
		t_conv(0, 0, 5);
		t_conv(1, 3, 2);
		t_conv(3, 1, 4);
		t_cont();
		t_acc();
		t_buf();
		t_cmp();
		conclude();
	end
	initial begin
		#720_000;
		fails++;
		conclude();
	end
endmodule // test_sac_top
`default_nettype wire
